/* tt_periodic_timer.sv */
// periodic interval tick timer with apb register access
//
// Our own choice: the APB register port.
`include "tt_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tt_periodic_timer (
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 ce,
   input  wire logic                 dbg_halt,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`TT_AW-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic                      irq
);

   logic [`TT_PRESC_W-1:0]  presc_r;
   logic [`TT_LIM_W-1:0]    interval_count_r;
   logic [`TT_LIM_W-1:0]    interval_count_nxt;
   logic [`TT_CNT_W-1:0]    elapsed_interval_count_r;
   logic [`TT_CNT_W-1:0]    elapsed_interval_count_nxt;
   logic [`TT_LIM_W-1:0]    interval_limit_r;
   logic                    timer_enable_bit_r;
   logic                    tick_irq_enable_r;
   logic                    tick_irq_enable_nxt;
   logic                    irq_mask_r;
   logic                    irq_mask_nxt;
   logic                    tick_flag_r;
   logic                    tick_flag_nxt;
   logic                    prdata_nxt_valid;
   logic [31:0]             rdata_w;
   logic                    tick_w;
   logic                    stopped_w;
   logic                    wrap_w;
   logic                    acc_w;
   logic                    done_w;
   logic                    wr_w;
   logic                    ack_rd_w;
   logic                    img_rd_w;
   logic                    mode_wr_w;
   logic                    status_w1c_w;
   logic                    mask_wr_w;
   tt_pkg::tt_sel_t         sel_w;

   // ---------------- apb decode ----------------
   always_comb begin
      case (paddr)
         `TT_OFF_MODE:     sel_w = tt_pkg::TT_SEL_MODE;
         `TT_OFF_STATUS:   sel_w = tt_pkg::TT_SEL_STATUS;
         `TT_OFF_VAL_ACK:  sel_w = tt_pkg::TT_SEL_VAL_ACK;
         `TT_OFF_VAL_IMG:  sel_w = tt_pkg::TT_SEL_VAL_IMG;
         `TT_OFF_IRQ_MASK: sel_w = tt_pkg::TT_SEL_IRQ_MASK;
         default:          sel_w = tt_pkg::TT_SEL_NONE;
      endcase
   end

   // one wait state: data is captured in the first access cycle, pready follows
   assign acc_w    = ce && psel && penable && !pready;
   assign done_w   = ce && psel && penable && pready;
   assign wr_w     = done_w && pwrite;
   // the clearing read acts when its data is captured, so the value returned and
   // the clear see the same counter state and no wrap can fall between them
   assign ack_rd_w = acc_w && !pwrite && (sel_w == tt_pkg::TT_SEL_VAL_ACK);
   assign img_rd_w = acc_w && !pwrite && (sel_w == tt_pkg::TT_SEL_VAL_IMG);
   assign mode_wr_w    = wr_w && (sel_w == tt_pkg::TT_SEL_MODE);
   assign status_w1c_w = wr_w && (sel_w == tt_pkg::TT_SEL_STATUS) && pwdata[`TT_FLAG_BIT];
   assign mask_wr_w    = wr_w && (sel_w == tt_pkg::TT_SEL_IRQ_MASK);

   always_comb begin
      rdata_w = 32'h00000000;
      prdata_nxt_valid = 1'b1;
      case (sel_w)
         tt_pkg::TT_SEL_MODE: begin
            rdata_w[`TT_LIM_MSB:0]   = interval_limit_r;
            rdata_w[`TT_EN_BIT]      = timer_enable_bit_r;
            rdata_w[`TT_IRQ_EN_BIT]  = tick_irq_enable_r;
         end
         tt_pkg::TT_SEL_STATUS:
            rdata_w[`TT_FLAG_BIT] = tick_flag_r;
         tt_pkg::TT_SEL_VAL_ACK,
         tt_pkg::TT_SEL_VAL_IMG:
            rdata_w = {elapsed_interval_count_r, interval_count_r};
         tt_pkg::TT_SEL_IRQ_MASK:
            rdata_w[`TT_MASK_BIT] = irq_mask_r;
         default:
            prdata_nxt_valid = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (acc_w) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 : rdata_w;
         pslverr <= !prdata_nxt_valid;
      end else if (done_w) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ---------------- mode and mask registers ----------------
   assign tick_irq_enable_nxt = mode_wr_w ? pwdata[`TT_IRQ_EN_BIT] : tick_irq_enable_r;
   assign irq_mask_nxt        = mask_wr_w ? pwdata[`TT_MASK_BIT] : irq_mask_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         interval_limit_r   <= `TT_LIM_RST;
         timer_enable_bit_r <= 1'b0;
         tick_irq_enable_r  <= 1'b0;
         irq_mask_r         <= `TT_MASK_RST;
      end else begin
         // a new limit only changes the compare value, counters are untouched
         if (mode_wr_w) begin
            interval_limit_r   <= pwdata[`TT_LIM_MSB:0];
            timer_enable_bit_r <= pwdata[`TT_EN_BIT];
         end
         tick_irq_enable_r <= tick_irq_enable_nxt;
         irq_mask_r        <= irq_mask_nxt;
      end
   end

   // ---------------- timebase ----------------
   // prescaler freezes with the counters in debug state so the phase is kept
   assign tick_w = ce && !dbg_halt && (presc_r == `TT_PRESC_LAST);

   always_ff @(posedge clk) begin
      if (srst) begin
         presc_r <= '0;
      end else if (ce && !dbg_halt) begin
         presc_r <= presc_r + 1'b1;
      end
   end

   // ---------------- interval and elapsed counters ----------------
   // enable is only looked at while parked at zero, so a clear lets the
   // current interval finish and a set starts a clean interval
   assign stopped_w = (interval_count_r == '0) && !timer_enable_bit_r;
   assign wrap_w    = tick_w && !stopped_w && (interval_count_r == interval_limit_r);

   always_comb begin
      interval_count_nxt         = interval_count_r;
      elapsed_interval_count_nxt = elapsed_interval_count_r;
      if (ack_rd_w) begin
         elapsed_interval_count_nxt = '0;
      end
      if (tick_w && !stopped_w) begin
         if (wrap_w) begin
            interval_count_nxt = '0;
            // modulo 2^12 by width; a wrap beside an ack counts as the first
            elapsed_interval_count_nxt = elapsed_interval_count_nxt + 1'b1;
         end else begin
            interval_count_nxt = interval_count_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         interval_count_r         <= '0;
         elapsed_interval_count_r <= '0;
      end else begin
         interval_count_r         <= interval_count_nxt;
         elapsed_interval_count_r <= elapsed_interval_count_nxt;
      end
   end

   // ---------------- tick flag and interrupt ----------------
   // a wrap in the same cycle as a clear keeps the flag set
   assign tick_flag_nxt = (tick_flag_r && !ack_rd_w && !status_w1c_w) || wrap_w;

   always_ff @(posedge clk) begin
      if (srst) begin
         tick_flag_r <= 1'b0;
         irq         <= 1'b0;
      end else begin
         tick_flag_r <= tick_flag_nxt;
         irq         <= tick_flag_nxt && tick_irq_enable_nxt && irq_mask_nxt;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_PRESC_STEP: assert property (
      tick_w |=> (presc_r == '0) ##1 !tick_w [*8])
      else $error("timebase tick not spaced by the divider");

   AST_WRAP_ZERO: assert property (
      wrap_w |=> (interval_count_r == '0) && tick_flag_r)
      else $error("wrap did not clear count or set flag");

   AST_COUNT_UP: assert property (
      tick_w && !stopped_w && !wrap_w |=> interval_count_r == $past(interval_count_r) + 1'b1)
      else $error("interval count did not advance by one");

   AST_ELAPSED_INC: assert property (
      wrap_w && !ack_rd_w |=>
         elapsed_interval_count_r == $past(elapsed_interval_count_r) + 1'b1)
      else $error("elapsed count did not advance on wrap");

   AST_IRQ_LEVEL: assert property (
      irq == (tick_flag_r && tick_irq_enable_r && irq_mask_r))
      else $error("interrupt output disagrees with flag and enables");

   AST_ACK_CLEAR: assert property (
      ack_rd_w && !wrap_w |=> !tick_flag_r && (elapsed_interval_count_r == '0) && !irq)
      else $error("acknowledging read did not clear flag and count");

   AST_IMAGE_QUIET: assert property (
      img_rd_w && !wrap_w |=> $stable(tick_flag_r) && $stable(elapsed_interval_count_r))
      else $error("image read disturbed timer state");

   AST_PARKED: assert property (
      stopped_w && !mode_wr_w |=> interval_count_r == '0)
      else $error("disabled timer left zero");

   AST_DEBUG_HOLD: assert property (
      dbg_halt && !ack_rd_w |=> $stable(interval_count_r) && $stable(elapsed_interval_count_r))
      else $error("counters moved in debug state");

   AST_APB_WAIT: assert property (
      acc_w |=> pready ##1 !pready)
      else $error("apb answer not one wait state");

   AST_PRESC_HOLD: assert property (
      dbg_halt |=> $stable(presc_r))
      else $error("timebase divider moved in debug state");

   // a low enable must freeze the whole block, bus side included
   AST_CE_FREEZE: assert property (
      !ce |=> $stable(presc_r) && $stable(interval_count_r) && $stable(elapsed_interval_count_r))
      else $error("counters moved with clock enable low");

   AST_CE_FLAG: assert property (
      !ce |=> $stable(tick_flag_r) && $stable(pready) && $stable(irq))
      else $error("flag or bus answer moved with clock enable low");

   AST_LIMIT_WRITE: assert property (
      mode_wr_w && !tick_w && !ack_rd_w |=>
         $stable(interval_count_r) && $stable(elapsed_interval_count_r))
      else $error("limit write disturbed the counters");

   AST_LIMIT_TAKEN: assert property (
      mode_wr_w |=> interval_limit_r == $past(pwdata[`TT_LIM_MSB:0]))
      else $error("limit field not taken from the write");

   AST_EN_TAKEN: assert property (
      mode_wr_w |=> (timer_enable_bit_r == $past(pwdata[`TT_EN_BIT])) &&
         (tick_irq_enable_r == $past(pwdata[`TT_IRQ_EN_BIT])))
      else $error("enable bits not taken from the write");

   AST_NO_TICK_NO_MOVE: assert property (
      !tick_w |=> $stable(interval_count_r))
      else $error("interval count moved between timebase ticks");

   AST_ELAPSED_ONLY_WRAP: assert property (
      !wrap_w && !ack_rd_w |=> $stable(elapsed_interval_count_r))
      else $error("elapsed count moved without a wrap");

   AST_FLAG_HOLD: assert property (
      tick_flag_r && !ack_rd_w && !status_w1c_w |=> tick_flag_r)
      else $error("tick flag dropped without a clear");

   AST_FLAG_RISE: assert property (
      !tick_flag_r && !wrap_w |=> !tick_flag_r)
      else $error("tick flag rose without a wrap");

   AST_W1C_CLEAR: assert property (
      status_w1c_w && !wrap_w |=> !tick_flag_r)
      else $error("write one to status did not clear the flag");

   // a wrap beside the clearing read must survive as a fresh event
   AST_ACK_WRAP: assert property (
      ack_rd_w && wrap_w |=> tick_flag_r &&
         (elapsed_interval_count_r == {{(`TT_CNT_W-1){1'b0}}, 1'b1}))
      else $error("wrap lost beside an acknowledging read");

   AST_STOPPED_NO_WRAP: assert property (
      stopped_w |-> !wrap_w)
      else $error("stopped timer wrapped");

   AST_START_FROM_ZERO: assert property (
      tick_w && (interval_count_r == '0) && timer_enable_bit_r && (interval_limit_r != '0) |=>
         interval_count_r == {{(`TT_LIM_W-1){1'b0}}, 1'b1})
      else $error("enabled timer did not step from zero");

   AST_PREADY_PULSE: assert property (
      pready && ce |=> !pready)
      else $error("ready stood longer than one cycle");

   AST_PSLVERR_WITH_READY: assert property (
      pslverr |-> pready)
      else $error("error flag without ready");

   AST_BAD_WRITE_IGNORED: assert property (
      wr_w && (sel_w == tt_pkg::TT_SEL_NONE) |=>
         $stable(interval_limit_r) && $stable(irq_mask_r))
      else $error("write to unmapped address changed a register");

   AST_MASK_TAKEN: assert property (
      mask_wr_w |=> irq_mask_r == $past(pwdata[`TT_MASK_BIT]))
      else $error("mask not taken from the write");

   AST_IRQ_OFF_NO_EN: assert property (
      !tick_irq_enable_r |-> !irq)
      else $error("interrupt raised with its enable low");

   AST_IMG_DATA: assert property (
      img_rd_w |=> prdata == {$past(elapsed_interval_count_r), $past(interval_count_r)})
      else $error("image read returned wrong counts");

   AST_ACK_DATA: assert property (
      ack_rd_w |=> prdata == {$past(elapsed_interval_count_r), $past(interval_count_r)})
      else $error("acknowledging read returned wrong counts");

   AST_STATUS_DATA: assert property (
      acc_w && !pwrite && (sel_w == tt_pkg::TT_SEL_STATUS) |=>
         prdata[`TT_FLAG_BIT] == $past(tick_flag_r))
      else $error("status read returned wrong flag");

   AST_MODE_DATA: assert property (
      acc_w && !pwrite && (sel_w == tt_pkg::TT_SEL_MODE) |=>
         prdata[`TT_LIM_MSB:0] == $past(interval_limit_r))
      else $error("mode read returned wrong limit");

endmodule

`default_nettype wire

/* tt_defines.svh */
// register map, field positions, reset values and timing figures of the tick timer
`ifndef TT_DEFINES_SVH
`define TT_DEFINES_SVH

`define TT_AW            8
`define TT_OFF_MODE      8'h00
`define TT_OFF_STATUS    8'h04
`define TT_OFF_VAL_ACK   8'h08
`define TT_OFF_VAL_IMG   8'h0C
`define TT_OFF_IRQ_MASK  8'h10

`define TT_LIM_W         20
`define TT_CNT_W         12
`define TT_LIM_MSB       19
`define TT_EN_BIT        24
`define TT_IRQ_EN_BIT    25
`define TT_FLAG_BIT      0
`define TT_MASK_BIT      0
`define TT_ELAPSED_LSB   20
`define TT_ELAPSED_MSB   31

`define TT_LIM_RST       20'hFFFFF
`define TT_MASK_RST      1'b1

`define TT_PRESC_W       4
`define TT_PRESC_DIV     16
`define TT_PRESC_LAST    4'hF

`endif

/* tt_pkg.sv */
// types shared by the tick timer
`default_nettype none
package tt_pkg;
   typedef enum logic [2:0] {
      TT_SEL_MODE     = 3'b000,
      TT_SEL_STATUS   = 3'b001,
      TT_SEL_VAL_ACK  = 3'b010,
      TT_SEL_VAL_IMG  = 3'b011,
      TT_SEL_IRQ_MASK = 3'b100,
      TT_SEL_NONE     = 3'b111
   } tt_sel_t;
endpackage
`default_nettype wire

/* tt_irq_sink.sv */
// interrupt controller model: watches the timer's level interrupt and times its rises
`timescale 1ns/100ps
`default_nettype none

module tt_irq_sink (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        irq,
   output logic      [31:0] rises,
   output logic      [31:0] period
);
   logic        irq_r;
   logic [31:0] since_r;

   // counts the cycles between two rises, so the tick period is seen whole
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_r   <= 1'b0;
         since_r <= 32'h0;
         rises   <= 32'h0;
         period  <= 32'h0;
      end else begin
         irq_r   <= irq;
         since_r <= (irq && !irq_r) ? 32'h1 : since_r + 32'h1;
         if (irq && !irq_r) begin
            rises  <= rises + 32'h1;
            period <= since_r;
         end
      end
   end
endmodule

`default_nettype wire

/* periodic_interval_timer_tb.sv */
// self-checking testbench of the tick timer over apb
`timescale 1ns/100ps
`default_nettype none

module periodic_interval_timer_tb;
   logic        clk, srst, dbg_halt, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rises, period, q, v;
   logic        e, ce;
   int          fails, n_compared;

   tt_periodic_timer tt_periodic_timer_inst (.clk(clk), .srst(srst), .ce(ce),
      .dbg_halt(dbg_halt), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   tt_irq_sink tt_irq_sink_inst (.clk(clk), .srst(srst), .irq(irq), .rises(rises),
      .period(period));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic conclude();
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   // the request stands until the rising edge at which pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 40) begin
         fails++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic wait_irq();
      int i;
      for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
      if (i == 400) begin
         fails++;
         conclude();
      end
   endtask

   initial begin
      fails = 0;
      n_compared = 0;
      srst = 1'b1;
      ce = 1'b1;
      dbg_halt = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rd(8'h00, 32'h000F_FFFF);
      rd(8'h04, 32'h0000_0000);
      rd(8'h08, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, e}, 32'h1);
      // limit 3 with enable and irq enable: four ticks of sixteen clocks each
      apb(1'b1, 8'h00, 32'h0300_0003);
      wait_irq();
      rd(8'h04, 32'h0000_0001);
      rd(8'h0C, 32'h0010_0000);
      rd(8'h0C, 32'h0010_0000);
      rd(8'h08, 32'h0010_0000);
      rd(8'h04, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
      wait_irq();
      @(posedge clk);
      chk(period, 32'h40);
      apb(1'b1, 8'h10, 32'h0);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h10, 32'h0000_0000);
      apb(1'b1, 8'h10, 32'h1);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h04, 32'h0000_0000);
      apb(1'b0, 8'h08, 32'h0);
      apb(1'b1, 8'h00, 32'h0100_0003);
      repeat (80) @(posedge clk);
      rd(8'h04, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0);
      dbg_halt <= 1'b1;
      apb(1'b0, 8'h0C, 32'h0);
      v = q;
      repeat (50) @(posedge clk);
      rd(8'h0C, v);
      dbg_halt <= 1'b0;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000_0003);
      repeat (100) @(posedge clk);
      apb(1'b0, 8'h0C, 32'h0);
      chk({12'h0, q[19:0]}, 32'h0);
      v = q;
      repeat (40) @(posedge clk);
      rd(8'h0C, v);
      conclude();
   end
endmodule

`default_nettype wire
